// ---- bench/dprh_ram_model.sv ----
// behavioural model of one port of the dual-port ram
// assumes host pins change just after the rising clock edge
`timescale 1ns/1ps

module dprh_ram_model (
   input wire logic clock,
   input wire logic cs_n,
   input wire logic rw_n,
   input wire logic oe_n,
   input wire logic [9:0] addr,
   input wire logic [7:0] io_out,
   input wire logic io_oe,
   input wire logic hold,
   output logic [7:0] io_in,
   output logic busy_n
);
   // ------------------------------------------------------------
   // storage and pins
   // ------------------------------------------------------------
   logic [7:0] mem [0:1023];
   logic [7:0] last_r;

   // far port contention, shown as busy to this port
   assign busy_n = !hold;
   // released pins show a changing pattern, not the last value
   assign io_in = (!cs_n && !oe_n && rw_n) ? mem[addr] : ~last_r;

   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      last_r <= io_in;
   end

   // write only in the overlap, and never while busy
   always_ff @(posedge clock) begin
      if (!cs_n && !rw_n && busy_n) begin
         mem[addr] <= io_oe ? io_out : ~io_out;
      end
   end
endmodule // dprh_ram_model

// ---- bench/testbench.sv ----
// self-checking bench for the dual-port ram host controller
// assumes the ram model stands on the far side of the port
`timescale 1ns/1ps

module testbench;
   logic clock, rst_n, req, req_we, req_oe_low, ack, busy_stall, irq;
   logic [9:0] req_addr, addr;
   logic [7:0] req_wdata, rdata, io_out, io_in;
   logic cs_n, rw_n, oe_n, io_oe, busy_n, int_n, hold;
   int err_count, total_checks, cyc, low_len, last_len;

   dprh_host u_dut (.clock(clock), .rst_n(rst_n), .req(req), .req_we(req_we),
      .req_oe_low(req_oe_low), .req_addr(req_addr), .req_wdata(req_wdata),
      .ack(ack), .busy_stall(busy_stall), .rdata(rdata), .irq(irq),
      .ram_cs_n(cs_n), .ram_rw_n(rw_n), .ram_oe_n(oe_n), .ram_addr(addr),
      .ram_io_out(io_out), .ram_io_oe(io_oe), .ram_io_in(io_in),
      .ram_busy_n(busy_n), .ram_int_n(int_n));

   dprh_ram_model u_ram (.clock(clock), .cs_n(cs_n), .rw_n(rw_n), .oe_n(oe_n),
      .addr(addr), .io_out(io_out), .io_oe(io_oe), .hold(hold),
      .io_in(io_in), .busy_n(busy_n));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic xfer(input logic we, input logic oel, input logic [9:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      req <= 1'h1;
      req_we <= we;
      req_oe_low <= oel;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clock);
      req <= 1'h0;
      #1;
      while (ack !== 1'h1 && n < 300) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n == 300) check(8'h00, 8'h01);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check({cs_n, rw_n, oe_n, io_oe, ack}, 8'h1C);
      $display("test reset done");
   endtask

   task automatic t_write_read();
      xfer(1'h1, 1'h0, 10'h155, 8'hA5);
      check(8'(last_len >= 4), 8'h01);
      xfer(1'h0, 1'h0, 10'h155, 8'h00);
      check(rdata, 8'hA5);
      xfer(1'h1, 1'h1, 10'h2AA, 8'h3C);
      check(8'(last_len >= 5), 8'h01);
      xfer(1'h1, 1'h0, 10'h2AB, 8'hC3);
      xfer(1'h0, 1'h0, 10'h2AA, 8'h00);
      check(rdata, 8'h3C);
      xfer(1'h0, 1'h0, 10'h2AB, 8'h00);
      check(rdata, 8'hC3);
      $display("test write read done");
   endtask

   task automatic t_busy();
      @(posedge clock);
      hold <= 1'h1;
      fork
         xfer(1'h1, 1'h0, 10'h0F0, 8'h77);
         begin
            repeat (30) @(posedge clock);
            #1;
            check(busy_stall, 8'h01);
            check(rw_n, 8'h01);
            check(u_ram.mem[10'h0F0], 8'h00);
            @(posedge clock);
            hold <= 1'h0;
         end
      join
      check(8'(last_len >= 2), 8'h01);
      xfer(1'h0, 1'h0, 10'h0F0, 8'h00);
      check(rdata, 8'h77);
      check(busy_stall, 8'h00);
      // busy arriving in the middle of a pulse must stretch it
      fork
         xfer(1'h1, 1'h0, 10'h0F1, 8'h5A);
         begin
            repeat (12) @(posedge clock);
            hold <= 1'h1;
            repeat (4) @(posedge clock);
            #1;
            check(busy_stall, 8'h01);
            check(rw_n, 8'h00);
            @(posedge clock);
            hold <= 1'h0;
            repeat (2) @(posedge clock);
            #1;
            check(rw_n, 8'h00);
         end
      join
      check(u_ram.mem[10'h0F1], 8'h5A);
      $display("test busy done");
   endtask

   task automatic t_irq();
      @(posedge clock);
      int_n <= 1'h0;
      repeat (2) @(posedge clock);
      #1;
      check(irq, 8'h01);
      @(posedge clock);
      int_n <= 1'h1;
      repeat (2) @(posedge clock);
      #1;
      check(irq, 8'h00);
      $display("test irq done");
   endtask

   // ------------------------------------------------------------
   // clock, monitors and main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   // pulse length and data pin clash watch; run length ceiling
   always @(posedge clock) begin
      cyc <= cyc + 1;
      low_len <= rw_n ? 0 : low_len + 1;
      if (rw_n === 1'h1 && low_len > 0) last_len <= low_len;
      if (io_oe && !cs_n && !oe_n && rw_n) check(8'h01, 8'h00);
      // with oe low the ram needs 30 ns after the strobe falls to let go
      if (io_oe === 1'h1 && !oe_n && low_len < 3) check(8'h01, 8'h00);
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      {rst_n, req, req_we, req_oe_low, hold} = '0;
      {req_addr, req_wdata, cyc, low_len, last_len} = '0;
      {err_count, total_checks} = '0;
      int_n = 1'h1;
      repeat (12) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      #1;
      t_reset();
      t_write_read();
      t_busy();
      t_irq();
      end_of_test();
   end
endmodule // testbench

// ---- rtl/dprh_defs.svh ----
// timing figures and pin-level constants for the dual-port ram host port
// assumes a single 100 MHz clock; every figure is the slowest grade
`ifndef DPRH_DEFS_SVH
`define DPRH_DEFS_SVH

`define DPRH_CLK_MHZ 100
`define DPRH_NS_CEIL(ns) ((((ns) * `DPRH_CLK_MHZ) + 999) / 1000)

// ------------------------------------------------------------
// write cycle figures, ns
// ------------------------------------------------------------
`define DPRH_WRITE_PULSE_WIDTH_NS 40
`define DPRH_WRITE_TO_FLOAT_TIME_NS 30
`define DPRH_DATA_SETUP_TO_WRITE_END_NS 20
`define DPRH_WRITE_RECOVERY_TIME_NS 0
`define DPRH_STROBE_HOLD_AFTER_RELEASE_NS 20

// ------------------------------------------------------------
// arbitration and read figures, ns
// ------------------------------------------------------------
`define DPRH_HOLD_FROM_ADDRESS_TIME_NS 45
`define DPRH_HOLD_FROM_SELECT_TIME_NS 35
`define DPRH_ADDRESS_ACCESS_NS 55
`define DPRH_WRITE_TO_DATA_DELAY_NS 80

// ------------------------------------------------------------
// derived cycle counts (least times rounded up, plus one cycle for arb, access and write-to-data delay)
// ------------------------------------------------------------
`define DPRH_WP_CYC `DPRH_NS_CEIL(`DPRH_WRITE_PULSE_WIDTH_NS)
`define DPRH_WZ_CYC `DPRH_NS_CEIL(`DPRH_WRITE_TO_FLOAT_TIME_NS)
`define DPRH_WZDW_CYC \
   `DPRH_NS_CEIL(`DPRH_WRITE_TO_FLOAT_TIME_NS + `DPRH_DATA_SETUP_TO_WRITE_END_NS)
`define DPRH_WH_CYC `DPRH_NS_CEIL(`DPRH_STROBE_HOLD_AFTER_RELEASE_NS)
`define DPRH_ARB_CYC (`DPRH_NS_CEIL(`DPRH_HOLD_FROM_ADDRESS_TIME_NS) + 1)
`define DPRH_ACC_CYC (`DPRH_NS_CEIL(`DPRH_ADDRESS_ACCESS_NS) + 1)
`define DPRH_RVD_CYC (`DPRH_NS_CEIL(`DPRH_WRITE_TO_DATA_DELAY_NS) + 1)

`endif

// ---- rtl/dprh_host.sv ----
// host controller for one port of an asynchronous 1K x 8 dual-port ram
// assumes pins are sampled synchronously and an external pull-up on busy
`timescale 1ns/1ps
`include "dprh_defs.svh"

module dprh_host #(
   parameter int AW = 10,
   parameter int DW = 8,
   parameter int TW = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req,
   input wire logic req_we,
   input wire logic req_oe_low,
   input wire logic [AW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   output logic ack,
   output logic busy_stall,
   output logic [DW-1:0] rdata,
   output logic irq,
   output logic ram_cs_n,
   output logic ram_rw_n,
   output logic ram_oe_n,
   output logic [AW-1:0] ram_addr,
   output logic [DW-1:0] ram_io_out,
   output logic ram_io_oe,
   input wire logic [DW-1:0] ram_io_in,
   input wire logic ram_busy_n,
   input wire logic ram_int_n
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   dprh_pkg::dprh_state_t st_r;
   logic we_r;
   logic oe_low_r;
   logic busy_seen_r;
   logic [3:0] elapsed_r;
   logic load_r;
   logic [TW-1:0] val_r;

   dprh_tmr_if #(.W(TW)) tif ();

   assign tif.load = load_r;
   assign tif.value = val_r;

   // a fresh load has not reached the counter yet, so done is stale then
   wire tm_ok = tif.done && !load_r;

   dprh_tmr #(.W(TW)) u_tmr (
      .clock(clock),
      .rst_n(rst_n),
      .t(tif)
   );

   // ------------------------------------------------------------
   // port sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= dprh_pkg::DPRH_IDLE;
         we_r <= 1'b0;
         oe_low_r <= 1'b0;
         busy_seen_r <= 1'b0;
         elapsed_r <= 4'h0;
         load_r <= 1'b0;
         val_r <= '0;
         ack <= 1'b0;
         busy_stall <= 1'b0;
         rdata <= '0;
         ram_cs_n <= 1'b1;
         ram_rw_n <= 1'b1;
         ram_oe_n <= 1'b1;
         ram_addr <= '0;
         ram_io_out <= '0;
         ram_io_oe <= 1'b0;
      end else begin
         load_r <= 1'b0;
         ack <= 1'b0;
         case (st_r)
            dprh_pkg::DPRH_IDLE: begin
               if (req) begin
                  // address moves only here, strobe still high
                  ram_addr <= req_addr;
                  ram_io_out <= req_wdata;
                  we_r <= req_we;
                  oe_low_r <= req_we && req_oe_low;
                  ram_cs_n <= 1'b0;
                  ram_oe_n <= req_we ? !req_oe_low : 1'b0;
                  load_r <= 1'b1;
                  val_r <= TW'(`DPRH_ARB_CYC);
                  st_r <= dprh_pkg::DPRH_ARB;
               end
            end
            dprh_pkg::DPRH_ARB: begin
               // let busy settle before any strobe; a held busy keeps us off it
               busy_stall <= !ram_busy_n;
               if (tm_ok && ram_busy_n) begin
                  busy_stall <= 1'b0;
                  load_r <= 1'b1;
                  if (we_r) begin
                     ram_rw_n <= 1'b0;
                     ram_io_oe <= !oe_low_r;
                     elapsed_r <= 4'h0;
                     busy_seen_r <= 1'b0;
                     val_r <= oe_low_r ? TW'(`DPRH_WZDW_CYC) : TW'(`DPRH_WP_CYC);
                     st_r <= dprh_pkg::DPRH_PULSE;
                  end else begin
                     val_r <= TW'(`DPRH_ACC_CYC);
                     st_r <= dprh_pkg::DPRH_READ;
                  end
               end
            end
            dprh_pkg::DPRH_PULSE: begin
               if (elapsed_r != 4'hF) begin
                  elapsed_r <= elapsed_r + 4'h1;
               end
               // with oe low the ram drivers need the float time to turn off
               if (oe_low_r && !ram_io_oe && elapsed_r >= 4'(`DPRH_WZ_CYC)) begin
                  ram_io_oe <= 1'b1;
               end
               if (!ram_busy_n) begin
                  busy_seen_r <= 1'b1;
                  busy_stall <= 1'b1;
               end else if (busy_seen_r) begin
                  busy_seen_r <= 1'b0;
                  busy_stall <= 1'b0;
                  load_r <= 1'b1;
                  val_r <= TW'(`DPRH_WH_CYC);
               end else if (tm_ok && ram_io_oe) begin
                  ram_rw_n <= 1'b1;
                  ram_io_oe <= 1'b0;
                  st_r <= dprh_pkg::DPRH_RECOV;
               end
            end
            dprh_pkg::DPRH_RECOV: begin
               // zero recovery: select may rise on the very next edge
               ram_cs_n <= 1'b1;
               ram_oe_n <= 1'b1;
               st_r <= dprh_pkg::DPRH_DONE;
            end
            dprh_pkg::DPRH_READ: begin
               // strobe is never touched here
               busy_stall <= !ram_busy_n;
               if (!ram_busy_n) begin
                  load_r <= 1'b1;
                  val_r <= TW'(`DPRH_RVD_CYC);
               end else if (tm_ok) begin
                  rdata <= ram_io_in;
                  ram_cs_n <= 1'b1;
                  ram_oe_n <= 1'b1;
                  st_r <= dprh_pkg::DPRH_DONE;
               end
            end
            dprh_pkg::DPRH_DONE: begin
               ack <= 1'b1;
               busy_stall <= 1'b0;
               st_r <= dprh_pkg::DPRH_IDLE;
            end
            default: begin
               st_r <= dprh_pkg::DPRH_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // interrupt flag from the opposite port
   // ------------------------------------------------------------
   // flag follows the pin; the device itself sets and clears it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= !ram_int_n;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_strobe_fall;
      $fell(ram_rw_n);
   endsequence

   sequence s_busy_release;
      $rose(ram_busy_n) && (st_r == dprh_pkg::DPRH_PULSE);
   endsequence

   property p_addr_under_read;
      @(posedge clock) disable iff (!rst_n)
         !$stable(ram_addr) |-> ram_rw_n && $past(ram_rw_n);
   endproperty
   a_addr_under_read: assert property (p_addr_under_read)
      else $error("address moved with strobe low");

   property p_drive_in_window;
      @(posedge clock) disable iff (!rst_n)
         ram_io_oe |-> !ram_cs_n && !ram_rw_n;
   endproperty
   a_drive_in_window: assert property (p_drive_in_window)
      else $error("data driven outside write window");

   property p_select_after_strobe;
      @(posedge clock) disable iff (!rst_n)
         $rose(ram_cs_n) |-> ram_rw_n && $past(ram_rw_n);
   endproperty
   a_select_after_strobe: assert property (p_select_after_strobe)
      else $error("select rose before strobe");

   property p_float_before_drive;
      @(posedge clock) disable iff (!rst_n)
         $rose(ram_io_oe) && !ram_oe_n |-> $past(!ram_rw_n, 3);
   endproperty
   a_float_before_drive: assert property (p_float_before_drive)
      else $error("data driven before ram outputs floated");

   property p_pulse_oe_low;
      @(posedge clock) disable iff (!rst_n)
         s_strobe_fall and !ram_oe_n |-> !ram_rw_n [*7];
   endproperty
   a_pulse_oe_low: assert property (p_pulse_oe_low)
      else $error("write pulse too short with oe low");

   property p_pulse_oe_high;
      @(posedge clock) disable iff (!rst_n)
         s_strobe_fall and ram_oe_n |-> !ram_rw_n [*5];
   endproperty
   a_pulse_oe_high: assert property (p_pulse_oe_high)
      else $error("write pulse shorter than minimum width");

   property p_hold_after_busy;
      @(posedge clock) disable iff (!rst_n)
         s_busy_release |-> !ram_rw_n [*3];
   endproperty
   a_hold_after_busy: assert property (p_hold_after_busy)
      else $error("strobe released too soon after busy");

   property p_read_strobe_high;
      @(posedge clock) disable iff (!rst_n)
         (st_r == dprh_pkg::DPRH_READ) |-> ram_rw_n && !ram_io_oe;
   endproperty
   a_read_strobe_high: assert property (p_read_strobe_high)
      else $error("strobe low during read");

   property p_no_strobe_under_busy;
      @(posedge clock) disable iff (!rst_n)
         s_strobe_fall |-> $past(ram_busy_n) && $past(!ram_cs_n, 2);
   endproperty
   a_no_strobe_under_busy: assert property (p_no_strobe_under_busy)
      else $error("strobe fell while busy or before select");

endmodule // dprh_host

// ---- rtl/dprh_pkg.sv ----
// types shared by the host port controller files
// no assumptions beyond a synthesizable SystemVerilog flow
package dprh_pkg;

   // gray along idle, arb, pulse, recov, done
   typedef enum logic [2:0] {
      DPRH_IDLE  = 3'h0,
      DPRH_ARB   = 3'h1,
      DPRH_PULSE = 3'h3,
      DPRH_RECOV = 3'h2,
      DPRH_DONE  = 3'h6,
      DPRH_READ  = 3'h7
   } dprh_state_t;

endpackage

// ---- rtl/dprh_tmr.sv ----
// down-counting delay timer; done while the count is spent
// assumes load is a one-cycle pulse from the controller, except in a read stalled by busy, where it stays high
`timescale 1ns/1ps

module dprh_tmr #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   dprh_tmr_if.tmr t
);

   logic [W-1:0] cnt_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (t.load) begin
         cnt_r <= t.value;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign t.done = (cnt_r == '0);

endmodule // dprh_tmr

// ---- rtl/dprh_tmr_if.sv ----
// carrier between the controller and its delay timer
// assumes both ends share one clock
`timescale 1ns/1ps

interface dprh_tmr_if #(
   parameter int W = 8
);
   logic load;
   logic [W-1:0] value;
   logic done;

   modport ctl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface
